/* hw/ctrw_core_timer.sv */
// core timer: prescaler, 15-stage chain, overflow and periodic flags, watchdog
// assumes Avalon-MM master on the same clock; reset is a synchronous input, wake passes two flops
`timescale 1ns/1ps
`include "ctrw_params.svh"

module ctrw_core_timer
    import ctrw_pkg::*;
#(
    parameter bit WATCHDOG_ON = 1'b1,
    parameter int POR_DELAY   = `CTRW_POR_DELAY
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ext_reset,
    input  wire logic        stop_exit,
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [7:0]  avs_writedata,
    output logic [7:0]       avs_readdata,
    output logic             avs_waitrequest,
    output logic             overflow_irq,
    output logic             periodic_irq,
    output logic             wake_request,
    output logic             watchdog_reset,
    output logic             stopped
);
    localparam int PS_W = $clog2(`CTRW_PRESCALE);
    localparam int PD_W = $clog2(POR_DELAY + 1);

    logic [PS_W-1:0] prescale_reg;
    ctrw_chain_t     chain_reg;
    ctrw_chain_t     chain_next;
    logic [PD_W-1:0] delay_reg;
    ctrw_pwr_e       pwr_reg;
    logic            ovf_flag_reg;
    logic            per_flag_reg;
    logic            ovf_en_reg;
    logic            per_en_reg;
    logic [1:0]      rate_reg;
    logic            bus_ack;
    logic            stop_exit_meta_reg;
    logic            stop_exit_sync_reg;
    logic            wr_sleep;
    logic            chain_clr;
    logic            step;
    logic            ovf_event;
    logic            per_event;
    logic            wr_csr;
    logic            wd_clear;
    logic            wd_timeout;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] offs);
        hit = (a == offs);
    endfunction

    // which chain bit carries the selected periodic tap
    function automatic logic [3:0] tap_bit(input logic [1:0] sel);
        tap_bit = 4'(11 + 32'(sel));
    endfunction

    // a request stands while its enable and its flag are both set
    function automatic logic irq_cause(input logic en, input logic flag);
        irq_cause = en && flag;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, then waitrequest low for one cycle
    // waitrequest is a flop so the master never sees a combinational glitch

    always_ff @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    assign bus_ack  = !avs_waitrequest;

    assign wr_csr   = avs_write && bus_ack && hit(avs_address, `CTRW_CSR_OFFS);
    assign wd_clear = avs_write && bus_ack && hit(avs_address, `CTRW_WDCLR_OFFS)
                      && !avs_writedata[0];
    assign wr_sleep = avs_write && bus_ack && hit(avs_address, `CTRW_SLEEP_OFFS)
                      && avs_writedata[0];

    always_ff @(posedge clock) begin
        if (rst) begin
            avs_readdata <= 8'h00;
        end else if (avs_read && !bus_ack) begin
            if (hit(avs_address, `CTRW_CSR_OFFS)) begin
                // clear bits always read zero
                avs_readdata <= {ovf_flag_reg, per_flag_reg, ovf_en_reg, per_en_reg,
                                 2'b00, rate_reg};
            end else if (hit(avs_address, `CTRW_CNT_OFFS)) begin
                avs_readdata <= chain_reg[7:0];
            end else if (hit(avs_address, `CTRW_SLEEP_OFFS)) begin
                avs_readdata <= {7'h00, pwr_reg == CTRW_PWR_STOPPED};
            end else begin
                avs_readdata <= `CTRW_UNMAPPED_DATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-on, stop and reset sequencing

    // stop exit is a pin: two flops before the sequencer looks at it
    always_ff @(posedge clock) begin
        if (rst) begin
            stop_exit_meta_reg <= 1'b0;
            stop_exit_sync_reg <= 1'b0;
        end else begin
            stop_exit_meta_reg <= stop_exit;
            stop_exit_sync_reg <= stop_exit_meta_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || wd_timeout) begin
            pwr_reg   <= CTRW_PWR_COUNT;
            delay_reg <= '0;
        end else begin
            case (pwr_reg)
                CTRW_PWR_COUNT: begin
                    // chain counts during the delay, then is cleared again
                    if (delay_reg == PD_W'(POR_DELAY - 1)) begin
                        pwr_reg <= CTRW_PWR_RUN;
                    end
                    delay_reg <= delay_reg + 1'b1;
                end
                CTRW_PWR_RUN: begin
                    if (wr_sleep) begin
                        pwr_reg <= CTRW_PWR_STOPPED;
                    end
                end
                CTRW_PWR_STOPPED: begin
                    if (stop_exit_sync_reg || ext_reset) begin
                        pwr_reg   <= CTRW_PWR_COUNT;
                        delay_reg <= '0;
                    end
                end
                default: pwr_reg <= CTRW_PWR_COUNT;
            endcase
        end
    end

    assign chain_clr = ext_reset
                       || (pwr_reg == CTRW_PWR_COUNT && delay_reg == PD_W'(POR_DELAY - 1))
                       || pwr_reg == CTRW_PWR_STOPPED;

    ////////////////////////////////////////////////////////////////////////
    // prescaler and divider chain; runs in wait since only stop, ext_reset and rst halt it

    always_ff @(posedge clock) begin
        if (rst || chain_clr) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + 1'b1;
        end
    end

    assign step       = &prescale_reg;
    assign chain_next = chain_reg + 1'b1;

    always_ff @(posedge clock) begin
        if (rst || chain_clr) begin
            chain_reg <= '0;
        end else if (step) begin
            chain_reg <= chain_next;
        end
    end

    // overflow every 256 steps, i.e. clock/1024
    assign ovf_event = step && (&chain_reg[7:0]);
    // selected bit falls: bit 11 falls once per clock/16384, taps 11..14
    assign per_event = step && chain_reg[tap_bit(rate_reg)]
                       && !chain_next[tap_bit(rate_reg)];

    ////////////////////////////////////////////////////////////////////////
    // control and flags

    always_ff @(posedge clock) begin
        if (rst) begin
            ovf_en_reg <= 1'b0;
            per_en_reg <= 1'b0;
            rate_reg   <= `CTRW_RATE_RESET;
        end else if (wr_csr) begin
            ovf_en_reg <= avs_writedata[`CTRW_CSR_OVF_EN];
            per_en_reg <= avs_writedata[`CTRW_CSR_PER_EN];
            rate_reg   <= avs_writedata[`CTRW_CSR_RATE_HI:`CTRW_CSR_RATE_LO];
        end
    end

    always_ff @(posedge clock) begin
        if (rst || chain_clr) begin
            ovf_flag_reg <= 1'b0;
        end else if (ovf_event) begin
            ovf_flag_reg <= 1'b1;
        end else if (wr_csr && avs_writedata[`CTRW_CSR_OVF_CLR]) begin
            ovf_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || chain_clr) begin
            per_flag_reg <= 1'b0;
        end else if (per_event) begin
            per_flag_reg <= 1'b1;
        end else if (wr_csr && avs_writedata[`CTRW_CSR_PER_CLR]) begin
            per_flag_reg <= 1'b0;
        end
    end

    // cpu mask bit is applied in the cpu; requests here are raw
    always_ff @(posedge clock) begin
        if (rst) begin
            overflow_irq <= 1'b0;
            periodic_irq <= 1'b0;
            wake_request <= 1'b0;
            stopped      <= 1'b0;
        end else begin
            overflow_irq <= irq_cause(ovf_en_reg, ovf_flag_reg);
            periodic_irq <= irq_cause(per_en_reg, per_flag_reg);
            wake_request <= irq_cause(ovf_en_reg, ovf_flag_reg)
                            || irq_cause(per_en_reg, per_flag_reg);
            stopped      <= pwr_reg == CTRW_PWR_STOPPED;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog: 8 periodic ticks; clear is async to chain so 7 to 8 periods

    ctrw_watchdog #(
        .STAGES (`CTRW_WD_STAGES)
    ) u_watchdog (
        .clock     (clock),
        .rst       (rst),
        .enable    (WATCHDOG_ON),
        .chain_clr (chain_clr),
        .tick      (per_event),
        .wd_clear  (wd_clear),
        .timeout   (wd_timeout)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= wd_timeout;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    // flags: set, hold and clear; then clear-bit readback, requests, reset values and tap bit
    ovf_set_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        ovf_event |=> ovf_flag_reg)
        else $error("overflow flag not set");
    ovf_hold_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        (!ovf_flag_reg && !ovf_event) |=> !ovf_flag_reg)
        else $error("overflow flag set without wrap");
    ovf_clear_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        (wr_csr && avs_writedata[3] && !ovf_event) |=> !ovf_flag_reg)
        else $error("overflow flag not cleared");
    per_set_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        per_event |=> per_flag_reg)
        else $error("periodic flag not set");
    per_hold_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        (!per_flag_reg && !per_event) |=> !per_flag_reg)
        else $error("periodic flag set without tap");
    per_clear_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        (wr_csr && avs_writedata[2] && !per_event) |=> !per_flag_reg)
        else $error("periodic flag not cleared");
    set_wins_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        (per_event && wr_csr && avs_writedata[2]) |=> per_flag_reg)
        else $error("periodic event lost on clear");
    clr_zero_a: assert property (@(posedge clock) disable iff (rst)
        (avs_read && bus_ack && hit(avs_address, `CTRW_CSR_OFFS))
            |-> (avs_readdata[3:2] == 2'b00))
        else $error("clear bits read nonzero");
    ovf_irq_a: assert property (@(posedge clock) disable iff (rst)
        overflow_irq |-> $past(irq_cause(ovf_en_reg, ovf_flag_reg)))
        else $error("overflow request without cause");
    per_irq_a: assert property (@(posedge clock) disable iff (rst)
        irq_cause(per_en_reg, per_flag_reg) |=> periodic_irq)
        else $error("periodic request missing");
    rate_reset_a: assert property (@(posedge clock)
        $past(rst) |-> (rate_reg == 2'h3 && !ovf_en_reg && !per_en_reg))
        else $error("reset pattern wrong");
    per_tap_a: assert property (@(posedge clock) disable iff (rst)
        per_event |-> (chain_reg[tap_bit(rate_reg) - 4'd1 -: 4'd1] == 1'b1))
        else $error("periodic tap mismatch");

    // chain clearing, watchdog and bus timing
    chain_clr_a: assert property (@(posedge clock) disable iff (rst)
        ext_reset |=> (chain_reg == '0 && prescale_reg == '0))
        else $error("chain not cleared");
    por_clear_a: assert property (@(posedge clock) disable iff (rst)
        chain_clr |=> (chain_reg == '0 && !ovf_flag_reg && !per_flag_reg))
        else $error("chain clear left state behind");
    stop_clear_a: assert property (@(posedge clock) disable iff (rst)
        (pwr_reg == CTRW_PWR_STOPPED) |=> (chain_reg == '0 && prescale_reg == '0))
        else $error("chain running in stop");
    wd_rst_a: assert property (@(posedge clock) disable iff (rst)
        wd_timeout |=> watchdog_reset)
        else $error("watchdog reset missing");
    count_hold_a: assert property (@(posedge clock) disable iff (rst || chain_clr)
        !step |=> $stable(chain_reg))
        else $error("count moved without step");
    bus_wait_a: assert property (@(posedge clock) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");

    ovf_seen_c: cover property (@(posedge clock) ovf_event);
    per_seen_c: cover property (@(posedge clock) per_event);
    wd_fire_c: cover property (@(posedge clock) wd_timeout);
    stop_c: cover property (@(posedge clock) pwr_reg == CTRW_PWR_STOPPED);
    wake_c: cover property (@(posedge clock) wake_request);
endmodule

/* hw/ctrw_params.svh */
// constants of the core timer: offsets, fields, reset values, timing counts
// assumes inclusion by bare name from the timer's design files
`ifndef CTRW_PARAMS_SVH
`define CTRW_PARAMS_SVH

`define CTRW_CSR_OFFS       16'h0008
`define CTRW_CNT_OFFS       16'h0009
`define CTRW_WDCLR_OFFS     16'h1ff0
`define CTRW_SLEEP_OFFS     16'h0f00
`define CTRW_CSR_OVF_FLAG   7
`define CTRW_CSR_PER_FLAG   6
`define CTRW_CSR_OVF_EN     5
`define CTRW_CSR_PER_EN     4
`define CTRW_CSR_OVF_CLR    3
`define CTRW_CSR_PER_CLR    2
`define CTRW_CSR_RATE_HI    1
`define CTRW_CSR_RATE_LO    0
`define CTRW_RATE_RESET     2'h3
`define CTRW_PRESCALE       4
`define CTRW_CHAIN_STAGES   15
`define CTRW_WD_STAGES      3
`define CTRW_POR_DELAY      4064
`define CTRW_UNMAPPED_DATA  8'h00

`endif

/* hw/ctrw_pkg.sv */
// types shared by the core timer design files
// assumes nothing beyond a SystemVerilog compiler
package ctrw_pkg;
    typedef enum logic [1:0] {
        CTRW_PWR_COUNT,
        CTRW_PWR_RUN,
        CTRW_PWR_STOPPED
    } ctrw_pwr_e;
    typedef logic [14:0] ctrw_chain_t;
endpackage

/* hw/ctrw_watchdog.sv */
// watchdog divide-by-eight stage fed by the periodic tap enable
// assumes one clock; tick is a one-cycle pulse from the divider chain
`timescale 1ns/1ps
`include "ctrw_params.svh"

module ctrw_watchdog
    import ctrw_pkg::*;
#(
    parameter int STAGES = `CTRW_WD_STAGES
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic chain_clr,
    input  wire logic tick,
    input  wire logic wd_clear,
    output logic      timeout
);
    logic [STAGES-1:0] wd_cnt_reg;

    // clear touches only this stage, never the chain upstream
    always_ff @(posedge clock) begin
        if (rst || chain_clr || wd_clear || !enable) begin
            wd_cnt_reg <= '0;
        end else if (tick) begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || chain_clr || !enable) begin
            timeout <= 1'b0;
        end else begin
            timeout <= tick && !wd_clear && (&wd_cnt_reg);
        end
    end

    wd_cleared_a: assert property (@(posedge clock) disable iff (rst)
        wd_clear |=> (wd_cnt_reg == '0 && !timeout))
        else $error("watchdog not cleared");
endmodule

/* sim/core_timer_rti_watchdog_tb.sv */
// testbench of the core timer: register sequences with expected values
// assumes the cpu model as bus master; power-on delay shortened to 16
`timescale 1ns/1ps
`include "ctrw_params.svh"

module core_timer_rti_watchdog_tb;
    localparam int POR = 16;
    logic        clock     = 1'b0;
    logic        rst       = 1'b1;
    logic        ext_reset = 1'b0;
    logic        stop_exit = 1'b0;
    logic [15:0] avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_writedata, avs_readdata;
    logic        overflow_irq, periodic_irq, wake_request, watchdog_reset, stopped;
    logic        wd_fired  = 1'b0;
    int          miscompares = 0;
    int          compares    = 0;

    always #25 clock = ~clock;
    always @(posedge clock) if (watchdog_reset === 1'b1) wd_fired <= 1'b1;

    ctrw_core_timer #(.WATCHDOG_ON(1'b1), .POR_DELAY(POR)) u_ctrw_core_timer (
        .clock(clock), .rst(rst), .ext_reset(ext_reset), .stop_exit(stop_exit),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .overflow_irq(overflow_irq),
        .periodic_irq(periodic_irq), .wake_request(wake_request),
        .watchdog_reset(watchdog_reset), .stopped(stopped));

    ctrw_cpu_model u_ctrw_cpu_model (
        .clock(clock), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        logic ok;
        u_ctrw_cpu_model.access(a, 1'b0, 8'h00, q, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic ok;
        logic [7:0] q;
        u_ctrw_cpu_model.access(a, 1'b1, d, q, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    // bounded wait for the periodic request, time taken at a settled point
    task automatic wait_tick(output realtime t);
        int n = 0;
        @(negedge clock);
        while (periodic_irq !== 1'b1 && n < 16500) begin
            @(negedge clock);
            n++;
        end
        t = $realtime;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // whole run is near 33k cycles
    initial begin
        #(60000 * 50);
        miscompares++;
        report_and_stop();
    end

    initial begin
        logic [7:0] v, q;
        logic       ok;
        realtime    t0, t1;
        int         k;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (POR + 24) @(posedge clock);
        rd(`CTRW_CSR_OFFS, q);
        check(q, 8'h03);
        rd(16'h0100, q);
        check(q, `CTRW_UNMAPPED_DATA);
        // samples 1024 then 512 cycles apart: one full count wrap, then half a wrap
        rd(`CTRW_CNT_OFFS, v);
        u_ctrw_cpu_model.clear_watchdog(ok);
        wr(`CTRW_CNT_OFFS, 8'h55);
        repeat (1015) @(posedge clock);
        rd(`CTRW_CNT_OFFS, q);
        check(q, v);
        repeat (509) @(posedge clock);
        rd(`CTRW_CNT_OFFS, q);
        check(q, v + 8'h80);
        // keep well away from the wrap before clearing
        k = 0;
        do begin
            rd(`CTRW_CNT_OFFS, v);
            k++;
        end while ((v < 8'h10 || v > 8'h90) && k < 200);
        wr(`CTRW_CSR_OFFS, 8'h0b);
        rd(`CTRW_CSR_OFFS, q);
        check(q, 8'h03);
        repeat (1021) @(posedge clock);
        rd(`CTRW_CSR_OFFS, q);
        check(q, 8'h83);
        wr(`CTRW_CSR_OFFS, 8'h23);
        repeat (3) @(negedge clock);
        check({6'h00, overflow_irq, wake_request}, 8'h03);
        wr(`CTRW_CSR_OFFS, 8'h2b);
        repeat (3) @(negedge clock);
        check({6'h00, overflow_irq, wake_request}, 8'h00);
        wr(`CTRW_CSR_OFFS, 8'hff);
        rd(`CTRW_CSR_OFFS, q);
        check(q & 8'h3f, 8'h33);
        // fastest tap; flag cleared again after the switch
        u_ctrw_cpu_model.clear_watchdog(ok);
        wr(`CTRW_CSR_OFFS, 8'h14);
        wr(`CTRW_CSR_OFFS, 8'h14);
        wait_tick(t0);
        check({7'h00, overflow_irq}, 8'h00);
        wr(`CTRW_CSR_OFFS, 8'h14);
        repeat (2) @(negedge clock);
        check({7'h00, periodic_irq}, 8'h00);
        wait_tick(t1);
        check({7'h00, (t1 - t0) >= 16383 * 50.0 && (t1 - t0) <= 16385 * 50.0}, 8'h01);
        @(posedge clock);
        ext_reset <= 1'b1;
        repeat (8) @(posedge clock);
        ext_reset <= 1'b0;
        rd(`CTRW_CNT_OFFS, q);
        check({7'h00, q <= 8'h01}, 8'h01);
        rd(`CTRW_CSR_OFFS, q);
        check(q & 8'hc0, 8'h00);
        wr(`CTRW_SLEEP_OFFS, 8'h01);
        repeat (2) @(negedge clock);
        check({7'h00, stopped}, 8'h01);
        rd(`CTRW_CNT_OFFS, q);
        check(q, 8'h00);
        stop_exit <= 1'b1;
        @(posedge clock);
        stop_exit <= 1'b0;
        k = 0;
        while (stopped !== 1'b0 && k < 400) begin
            @(negedge clock);
            k++;
        end
        check({7'h00, stopped}, 8'h00);
        repeat (40) @(posedge clock);
        rd(`CTRW_CNT_OFFS, q);
        check({7'h00, q != 8'h00}, 8'h01);
        check({7'h00, wd_fired}, 8'h00);
        report_and_stop();
    end
endmodule

/* sim/ctrw_cpu_model.sv */
// cpu side model: avalon master issuing byte register accesses
// assumes one shared clock and a slave that drops waitrequest per access
`timescale 1ns/1ps
`include "ctrw_params.svh"

module ctrw_cpu_model (
    input  wire logic        clock,
    output logic [15:0]      avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [7:0]       avs_writedata,
    input  wire logic [7:0]  avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address   = 16'h0000;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // request held until waitrequest is sampled low at a rising edge
    task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_read      <= ~w;
        avs_write     <= w;
        avs_writedata <= d;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 16) begin
            @(posedge clock);
            n++;
        end
        q  = avs_readdata;
        ok = (n < 16);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // software keeps the watchdog alive, and does so before any tap change
    task automatic clear_watchdog(output logic ok);
        logic [7:0] q;
        access(`CTRW_WDCLR_OFFS, 1'b1, 8'h00, q, ok);
    endtask
endmodule
